// file: design/tpf_pkg.sv
// Package for the test pattern frame timing block: register map, reset values,
// field positions, output carriers and sequencer states.
// Assumes byte-wide registers reached through the device's internal register port.
package tpf_pkg;
	localparam logic [7:0] ADDR_CTL = 8'h01;
	localparam logic [7:0] ADDR_CFG = 8'h02;
	localparam logic [7:0] ADDR_CSI = 8'h03;
	localparam logic [7:0] ADDR_LINE_HI = 8'h04;
	localparam logic [7:0] ADDR_LINE_LO = 8'h05;
	localparam logic [7:0] ADDR_BAR_HI = 8'h06;
	localparam logic [7:0] ADDR_BAR_LO = 8'h07;
	localparam logic [7:0] ADDR_ACT_HI = 8'h08;
	localparam logic [7:0] ADDR_ACT_LO = 8'h09;
	localparam logic [7:0] ADDR_TOT_HI = 8'h0a;
	localparam logic [7:0] ADDR_TOT_LO = 8'h0b;
	localparam logic [7:0] ADDR_PD_HI = 8'h0c;
	localparam logic [7:0] ADDR_PD_LO = 8'h0d;
	localparam logic [7:0] ADDR_VBP = 8'h0e;
	localparam logic [7:0] ADDR_VFP = 8'h0f;
	localparam logic [7:0] RST_CTL = 8'h00;
	localparam logic [7:0] RST_CFG = 8'h33;
	localparam logic [7:0] RST_CSI = 8'h24;
	localparam logic [7:0] RST_LINE_HI = 8'h07;
	localparam logic [7:0] RST_LINE_LO = 8'h80;
	localparam logic [7:0] RST_BAR_HI = 8'h00;
	localparam logic [7:0] RST_BAR_LO = 8'hf0;
	localparam logic [7:0] RST_ACT_HI = 8'h01;
	localparam logic [7:0] RST_ACT_LO = 8'he0;
	localparam logic [7:0] RST_TOT_HI = 8'h02;
	localparam logic [7:0] RST_TOT_LO = 8'h0d;
	localparam logic [7:0] RST_PD_HI = 8'h0c;
	localparam logic [7:0] RST_PD_LO = 8'h67;
	localparam logic [7:0] RST_VBP = 8'h21;
	localparam logic [7:0] RST_VFP = 8'h0a;
	// Index 0 is unmapped and stays zero
	localparam logic [15:0][7:0] REG_RESET = {RST_VFP, RST_VBP, RST_PD_LO, RST_PD_HI,
		RST_TOT_LO, RST_TOT_HI, RST_ACT_LO, RST_ACT_HI, RST_BAR_LO, RST_BAR_HI,
		RST_LINE_LO, RST_LINE_HI, RST_CSI, RST_CFG, RST_CTL, 8'h00};
	// Writable bits per register; reserved bits read zero
	localparam logic [7:0] MASK_CTL = 8'h01;
	localparam logic [7:0] MASK_CFG = 8'hbf;
	localparam logic [7:0] MASK_FULL = 8'hff;
	localparam int CTL_ON_BIT = 0;
	localparam int CFG_FIXED_BIT = 7;
	localparam int CFG_BARS_LSB = 4;
	localparam int CFG_BLOCK_LSB = 0;
	localparam int CSI_VC_LSB = 6;
	localparam int CSI_DT_LSB = 0;

	typedef struct packed {
		logic frame_start;
		logic frame_end;
		logic blank_line;
		logic line_start;
		logic [1:0] packet_virtual_channel;
		logic [5:0] packet_data_type;
		logic [15:0] word_count;
	} tpf_pkt_t;

	typedef struct packed {
		logic valid;
		logic last;
		logic [3:0] color_idx;
	} tpf_byte_t;

	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ACTIVE} tpf_state_t;
endpackage : tpf_pkg

// file: design/tpf_frame_timing.sv
// Frame and line timing of the built-in test pattern generator.
// Assumes period_tick pulses once per 40/forward_link_rate unit, in clk_sys.
// Operation
// R1 - Active line carries line-size bytes
// R2 - Non-final bars are bar-size bytes wide
// R3 - Final bar takes the remaining bytes
// R4 - Bar size from offsets 0x6, 0x7
// R5 - Active-lines setting gives active lines per frame
// R6 - Frame spans total-lines count including blanking
// R7 - Lines spaced by line period units
// R8 - Back porch blank lines after frame start
// R9 - Front porch blank lines before frame end
// R10 - Generator runs only while enabled
// R11 - Bar count select gives 1/2/4/8 bars
// R12 - Fixed select chooses fixed color pattern
// R13 - Packets carry programmed channel and type
// R14 - Line timer paces blank lines too
`timescale 1ns/1ps
`default_nettype none
module tpf_frame_timing (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic period_tick,
	input wire logic byte_ready,
	output tpf_pkg::tpf_pkt_t pkt_out,
	output tpf_pkg::tpf_byte_t byte_out,
	output logic frame_busy
);
	logic [15:0][7:0] regs_reg, regs_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [15:0] per_cnt_reg, per_cnt_next;
	tpf_pkg::tpf_state_t state_reg, state_next;
	logic [15:0] line_idx_reg, line_idx_next;
	logic pend_reg, pend_next, fe_done_reg, fe_done_next;
	logic [15:0] byte_cnt_reg, byte_cnt_next, bar_cnt_reg, bar_cnt_next;
	logic [3:0] bar_idx_reg, bar_idx_next, fix_cnt_reg, fix_cnt_next;
	tpf_pkg::tpf_pkt_t pkt_reg, pkt_next;

	function automatic logic [7:0] wr_mask(input logic [3:0] idx);
		unique case (idx)
			tpf_pkg::ADDR_CTL[3:0]: wr_mask = tpf_pkg::MASK_CTL;
			tpf_pkg::ADDR_CFG[3:0]: wr_mask = tpf_pkg::MASK_CFG;
			4'h0: wr_mask = 8'h00;
			default: wr_mask = tpf_pkg::MASK_FULL;
		endcase
	endfunction : wr_mask

	function automatic logic map_hit(input logic [7:0] a);
		map_hit = (a[7:4] == 4'h0) && (a[3:0] != 4'h0);
	endfunction : map_hit

	logic on, fixed, start, boundary, byte_acc, is_last, last_bar, wrap;
	logic [7:0] cfg, csi;
	logic [15:0] line_bytes, bar_width, act_lines, tot_lines, period;
	logic [7:0] vbp, vfp;
	logic [3:0] nbars, block;
	logic [17:0] act_end, fe_line;

	assign on = regs_reg[tpf_pkg::ADDR_CTL[3:0]][tpf_pkg::CTL_ON_BIT];
	assign cfg = regs_reg[tpf_pkg::ADDR_CFG[3:0]];
	assign csi = regs_reg[tpf_pkg::ADDR_CSI[3:0]];
	assign fixed = cfg[tpf_pkg::CFG_FIXED_BIT];
	// R11 bar count decode
	assign nbars = 4'(4'h1 << cfg[tpf_pkg::CFG_BARS_LSB +: 2]);
	// Block size 0 would wrap on every byte, so it acts as 1
	assign block = (cfg[tpf_pkg::CFG_BLOCK_LSB +: 4] == 4'h0) ? 4'h1
		: cfg[tpf_pkg::CFG_BLOCK_LSB +: 4];
	assign line_bytes = {regs_reg[tpf_pkg::ADDR_LINE_HI[3:0]], regs_reg[tpf_pkg::ADDR_LINE_LO[3:0]]};
	// R4 bar size bytes
	assign bar_width = {regs_reg[tpf_pkg::ADDR_BAR_HI[3:0]], regs_reg[tpf_pkg::ADDR_BAR_LO[3:0]]};
	assign act_lines = {regs_reg[tpf_pkg::ADDR_ACT_HI[3:0]], regs_reg[tpf_pkg::ADDR_ACT_LO[3:0]]};
	assign tot_lines = {regs_reg[tpf_pkg::ADDR_TOT_HI[3:0]], regs_reg[tpf_pkg::ADDR_TOT_LO[3:0]]};
	assign period = {regs_reg[tpf_pkg::ADDR_PD_HI[3:0]], regs_reg[tpf_pkg::ADDR_PD_LO[3:0]]};
	assign vbp = regs_reg[tpf_pkg::ADDR_VBP[3:0]];
	assign vfp = regs_reg[tpf_pkg::ADDR_VFP[3:0]];
	assign act_end = 18'(vbp) + 18'(act_lines);
	assign fe_line = act_end + 18'(vfp);

	// Register port
	always_comb begin
		regs_next = regs_reg;
		rdata_next = rdata_reg;
		if (reg_wr_en && map_hit(reg_addr)) begin
			regs_next[reg_addr[3:0]] = reg_wdata & wr_mask(reg_addr[3:0]);
		end
		if (reg_rd_en) begin
			rdata_next = map_hit(reg_addr) ? regs_reg[reg_addr[3:0]] : 8'h00;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			regs_reg <= tpf_pkg::REG_RESET;
			rdata_reg <= 8'h00;
		end else begin
			regs_reg <= regs_next;
			rdata_reg <= rdata_next;
		end
	end
	assign reg_rdata = rdata_reg;

	// R7 line period timer, period 0 acts as 1
	assign boundary = on && period_tick && (per_cnt_reg + 16'h0001 >= period);
	always_comb begin
		per_cnt_next = per_cnt_reg;
		if (!on || boundary) begin
			per_cnt_next = 16'h0000;
		end else if (period_tick) begin
			per_cnt_next = per_cnt_reg + 16'h0001;
		end
	end

	// R14 every line, blank or active, waits for a boundary
	assign start = on && pend_reg && (state_reg != tpf_pkg::ST_ACTIVE);
	assign byte_acc = (state_reg == tpf_pkg::ST_ACTIVE) && byte_ready;
	assign is_last = (byte_cnt_reg == line_bytes - 16'h0001);
	assign last_bar = (bar_idx_reg == nbars - 4'h1);
	// R6 frame wraps after total-lines lines
	assign wrap = (17'(line_idx_reg) + 17'h0_0001 >= 17'(tot_lines));

	always_comb begin
		state_next = state_reg;
		line_idx_next = line_idx_reg;
		fe_done_next = fe_done_reg;
		byte_cnt_next = byte_cnt_reg;
		bar_cnt_next = bar_cnt_reg;
		bar_idx_next = bar_idx_reg;
		fix_cnt_next = fix_cnt_reg;
		// A boundary in the same cycle as the start keeps the request
		pend_next = boundary || (pend_reg && !start);
		pkt_next = '0;
		// R13 channel and type from register
		pkt_next.packet_virtual_channel = csi[tpf_pkg::CSI_VC_LSB +: 2];
		pkt_next.packet_data_type = csi[tpf_pkg::CSI_DT_LSB +: 6];
		pkt_next.word_count = line_bytes;
		if (!on) begin
			// R10 disabled generator idles
			state_next = tpf_pkg::ST_IDLE;
			line_idx_next = 16'h0000;
			pend_next = 1'b0;
			fe_done_next = 1'b0;
		end else if (start) begin
			state_next = tpf_pkg::ST_WAIT;
			line_idx_next = wrap ? 16'h0000 : line_idx_reg + 16'h0001;
			if (line_idx_reg == 16'h0000) begin
				pkt_next.frame_start = 1'b1;
				fe_done_next = 1'b0;
			end
			if (18'(line_idx_reg) < 18'(vbp)) begin
				// R8 back porch
				pkt_next.blank_line = 1'b1;
			end else if (18'(line_idx_reg) < act_end) begin
				// R5 active line
				pkt_next.line_start = 1'b1;
				byte_cnt_next = 16'h0000;
				bar_cnt_next = 16'h0000;
				bar_idx_next = 4'h0;
				fix_cnt_next = 4'h0;
				if (line_bytes != 16'h0000) begin
					state_next = tpf_pkg::ST_ACTIVE;
				end
			end else if (18'(line_idx_reg) < fe_line) begin
				// R9 front porch
				pkt_next.blank_line = 1'b1;
			end else if (!fe_done_reg) begin
				pkt_next.frame_end = 1'b1;
				fe_done_next = 1'b1;
			end
			// Short total count still closes the frame it opened
			if (wrap && !fe_done_reg && (18'(line_idx_reg) < fe_line)) begin
				pkt_next.frame_end = 1'b1;
			end
		end else if (byte_acc) begin
			if (is_last) begin
				// R1 line ends at line size
				state_next = tpf_pkg::ST_WAIT;
			end else begin
				byte_cnt_next = byte_cnt_reg + 16'h0001;
				fix_cnt_next = (fix_cnt_reg + 4'h1 >= block) ? 4'h0 : fix_cnt_reg + 4'h1;
				// R2 bar advances at bar size
				if ((bar_cnt_reg + 16'h0001 >= bar_width) && !last_bar) begin
					bar_idx_next = bar_idx_reg + 4'h1;
					bar_cnt_next = 16'h0000;
				end else begin
					// R3 final bar absorbs the rest
					bar_cnt_next = bar_cnt_reg + 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			per_cnt_reg <= 16'h0000;
			state_reg <= tpf_pkg::ST_IDLE;
			line_idx_reg <= 16'h0000;
			pend_reg <= 1'b0;
			fe_done_reg <= 1'b0;
			byte_cnt_reg <= 16'h0000;
			bar_cnt_reg <= 16'h0000;
			bar_idx_reg <= 4'h0;
			fix_cnt_reg <= 4'h0;
			pkt_reg <= '0;
		end else begin
			per_cnt_reg <= per_cnt_next;
			state_reg <= state_next;
			line_idx_reg <= line_idx_next;
			pend_reg <= pend_next;
			fe_done_reg <= fe_done_next;
			byte_cnt_reg <= byte_cnt_next;
			bar_cnt_reg <= bar_cnt_next;
			bar_idx_reg <= bar_idx_next;
			fix_cnt_reg <= fix_cnt_next;
			pkt_reg <= pkt_next;
		end
	end

	assign pkt_out = pkt_reg;
	assign byte_out.valid = (state_reg == tpf_pkg::ST_ACTIVE);
	assign byte_out.last = (state_reg == tpf_pkg::ST_ACTIVE) && is_last;
	// R12 fixed pattern walks the block, bars otherwise
	assign byte_out.color_idx = fixed ? fix_cnt_reg : bar_idx_reg;
	assign frame_busy = (state_reg != tpf_pkg::ST_IDLE);

	sequence s_last_taken;
		byte_acc && is_last;
	endsequence
	sequence s_bar_step;
		byte_acc && !is_last && (bar_cnt_reg + 16'h0001 >= bar_width) && !last_bar;
	endsequence

	a_line_bytes_end: assert property (@(posedge clk_sys) disable iff (!arst_n) // R1
		s_last_taken |=> !byte_out.valid && $past(byte_cnt_reg) == line_bytes - 16'h0001)
		else $error("active line did not end at line size");
	a_bar_step_width: assert property (@(posedge clk_sys) disable iff (!arst_n) // R2
		s_bar_step |=> bar_idx_reg == $past(bar_idx_reg) + 4'h1 && bar_cnt_reg == 16'h0000)
		else $error("bar did not advance at bar size");
	a_final_bar_hold: assert property (@(posedge clk_sys) disable iff (!arst_n) // R3
		(byte_acc && last_bar && !is_last) |=> last_bar && bar_cnt_reg == $past(bar_cnt_reg) + 16'h0001)
		else $error("final bar did not take remaining bytes");
	a_bar_reg_write: assert property (@(posedge clk_sys) disable iff (!arst_n) // R4
		(reg_wr_en && reg_addr == tpf_pkg::ADDR_BAR_LO) |=> bar_width[7:0] == $past(reg_wdata))
		else $error("bar size low byte not taken from offset 0x7");
	a_active_line_pos: assert property (@(posedge clk_sys) disable iff (!arst_n) // R5
		$rose(byte_out.valid) |-> 18'($past(line_idx_reg)) >= 18'(vbp)
			&& 18'($past(line_idx_reg)) < act_end)
		else $error("active line outside active region");
	a_frame_wraps: assert property (@(posedge clk_sys) disable iff (!arst_n) // R6
		(start && wrap) |=> line_idx_reg == 16'h0000 ##0 (!pkt_out.frame_start || !wrap))
		else $error("frame did not wrap at total lines");
	a_period_restart: assert property (@(posedge clk_sys) disable iff (!arst_n) // R7
		boundary |=> per_cnt_reg == 16'h0000 ##1 pend_reg || $past(start))
		else $error("line period timer did not restart");
	a_back_porch: assert property (@(posedge clk_sys) disable iff (!arst_n) // R8
		(pkt_out.frame_start && vbp != 8'h00) |-> pkt_out.blank_line && !pkt_out.line_start)
		else $error("frame start not followed by back porch blank line");
	a_front_porch: assert property (@(posedge clk_sys) disable iff (!arst_n) // R9
		(pkt_out.blank_line && !pkt_out.frame_start) |-> 18'($past(line_idx_reg)) < 18'(vbp)
			|| (18'($past(line_idx_reg)) >= act_end && 18'($past(line_idx_reg)) < fe_line))
		else $error("blank line outside porch regions");
	a_disabled_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n) // R10
		(!on [*2]) |-> !frame_busy && !pkt_out.frame_start && !pkt_out.frame_end
			&& !pkt_out.blank_line && !pkt_out.line_start)
		else $error("generator active while disabled");
	a_fixed_walk: assert property (@(posedge clk_sys) disable iff (!arst_n) // R12
		(fixed && byte_out.valid) |-> byte_out.color_idx < block)
		else $error("fixed pattern index beyond block size");
	a_packet_ids: assert property (@(posedge clk_sys) disable iff (!arst_n) // R13
		pkt_out.line_start |-> pkt_out.packet_data_type == 6'($past(csi) >> tpf_pkg::CSI_DT_LSB)
			&& pkt_out.packet_virtual_channel == 2'($past(csi) >> tpf_pkg::CSI_VC_LSB))
		else $error("packet data type not programmed value");
	a_line_on_tick: assert property (@(posedge clk_sys) disable iff (!arst_n) // R14
		(boundary && !pend_reg && state_reg != tpf_pkg::ST_ACTIVE) |=> start || !on)
		else $error("line did not start on the period boundary");
endmodule : tpf_frame_timing
`default_nettype wire

// file: tb/tpf_sink_model.sv
// Downstream packet path model: takes pattern bytes, stalls on request, tallies events.
// Assumes it shares clk_sys with the generator and sees its outputs directly.
`timescale 1ns/1ps
`default_nettype none
module tpf_sink_model (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic slow,
	input wire tpf_pkg::tpf_pkt_t pkt_out,
	input wire tpf_pkg::tpf_byte_t byte_out,
	output logic byte_ready,
	output var int cnt [4],
	output var int hist [16],
	output var int last_pos,
	output logic [15:0] wc_seen,
	output logic [7:0] id_seen
);
	int pos;
	// Half-rate acceptance when slow, to make the generator hold bytes
	initial begin
		byte_ready = 1'b0;
		forever @(negedge clk_sys) byte_ready <= slow ? ~byte_ready : 1'b1;
	end
	// Counters are cumulative; the bench takes differences between snapshots
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= '{0, 0, 0, 0};
			pos <= 0;
			last_pos <= 0;
		end else begin
			cnt[0] <= cnt[0] + int'(pkt_out.frame_start);
			cnt[1] <= cnt[1] + int'(pkt_out.frame_end);
			cnt[2] <= cnt[2] + int'(pkt_out.blank_line);
			cnt[3] <= cnt[3] + int'(pkt_out.line_start);
			if (pkt_out.line_start) begin
				wc_seen <= pkt_out.word_count;
				id_seen <= {pkt_out.packet_virtual_channel, pkt_out.packet_data_type};
				// A line that never ends must not leave an old length behind
				last_pos <= 0;
			end
			// A line start restarts the position and the bar tally
			if (byte_out.valid && byte_ready) begin
				pos <= (pkt_out.line_start ? 0 : pos) + 1;
				if (byte_out.last) last_pos <= (pkt_out.line_start ? 0 : pos) + 1;
			end else if (pkt_out.line_start) begin
				pos <= 0;
			end
			foreach (hist[i]) begin
				hist[i] <= (pkt_out.line_start ? 0 : hist[i])
					+ int'(byte_out.valid && byte_ready && byte_out.color_idx == 4'(i));
			end
		end
	end
endmodule : tpf_sink_model
`default_nettype wire

// file: tb/tpf_frame_timing_test.sv
// Self-checking bench for the frame timing block: register checks, then whole frames.
// Assumes a tick every 16 cycles and a small register image to keep frames short.
`timescale 1ns/1ps
`default_nettype none
module tpf_frame_timing_test;
	logic clk_sys, arst_n, reg_wr_en, reg_rd_en, period_tick, slow, byte_ready, frame_busy;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	tpf_pkg::tpf_pkt_t pkt_out;
	tpf_pkg::tpf_byte_t byte_out;
	int cnt [4];
	int hist [16];
	int e [8];
	int last_pos, err_total, compares, cyc, t0, nb, c;
	logic [15:0] wc_seen;
	logic [7:0] id_seen;
	// Line 17 bytes, bar 2, 2 active of 8 total, period 3, porches 1, channel 2
	logic [15:0] prog [13] = '{16'h03a4, 16'h0400, 16'h0511, 16'h0600, 16'h0702, 16'h0800,
		16'h0902, 16'h0a00, 16'h0b08, 16'h0c00, 16'h0d03, 16'h0e01, 16'h0f01};
	tpf_frame_timing DUT (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .period_tick(period_tick), .byte_ready(byte_ready),
		.pkt_out(pkt_out), .byte_out(byte_out), .frame_busy(frame_busy));
	tpf_sink_model sink (.clk_sys(clk_sys), .arst_n(arst_n), .slow(slow), .pkt_out(pkt_out),
		.byte_out(byte_out), .byte_ready(byte_ready), .cnt(cnt), .hist(hist),
		.last_pos(last_pos), .wc_seen(wc_seen), .id_seen(id_seen));
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) cyc++;
	always @(negedge clk_sys) period_tick <= (cyc % 16 == 0);
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = v;
		reg_wr_en = 1'b1;
		@(negedge clk_sys);
		reg_wr_en = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge clk_sys);
		reg_rd_en = 1'b0;
		@(negedge clk_sys);
		v = reg_rdata;
	endtask : rd
	task automatic wait_fs();
		int k;
		k = 0;
		do begin
			@(negedge clk_sys);
			k++;
		end while (pkt_out.frame_start !== 1'b1 && k < 3000);
		if (k >= 3000) check("frame_start_wait", 0, 1);
	endtask : wait_fs
	// The first full frame is measured, from its frame start to the next frame start
	task automatic run_frame(input string name, input logic [7:0] cfg);
		int c0 [4];
		wr(8'h01, 8'h00);
		wr(8'h02, cfg);
		wr(8'h01, 8'h01);
		wait_fs();
		c0 = cnt;
		t0 = cyc;
		wait_fs();
		check("frame_cycles", cyc - t0, 8 * 3 * 16);
		check("frame_starts", cnt[0] - c0[0], 1);
		check("frame_ends", cnt[1] - c0[1], 1);
		check("blank_lines", cnt[2] - c0[2], 2);
		check("active_lines", cnt[3] - c0[3], 2);
		check("line_bytes", last_pos, 17);
		check("word_count", wc_seen, 17);
		check("packet_id", id_seen, 8'ha4);
		for (int i = 0; i < 8; i++) check("bar_bytes", hist[i], e[i]);
		$display("test %s done", name);
	endtask : run_frame
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : report_and_stop
	initial begin
		#400_000;
		err_total++;
		report_and_stop();
	end
	initial begin
		{arst_n, reg_wr_en, reg_rd_en, slow, reg_addr, reg_wdata} = '0;
		repeat (2) @(negedge clk_sys);
		arst_n = 1'b1;
		// Address 16 is past the map and must read zero
		for (int a = 0; a < 17; a++) begin
			rd(8'(a), d);
			check("reset_value", d, (a < 16) ? tpf_pkg::REG_RESET[a] : 8'h00);
		end
		wr(8'h02, 8'hff);
		rd(8'h02, d);
		check("cfg_reserved", d, 8'hbf);
		wr(8'h06, 8'h12);
		wr(8'h07, 8'h34);
		rd(8'h06, d);
		check("bar_high", d, 8'h12);
		rd(8'h07, d);
		check("bar_low", d, 8'h34);
		$display("test registers done");
		foreach (prog[i]) wr(prog[i][15:8], prog[i][7:0]);
		for (int s = 0; s < 4; s++) begin
			nb = 1 << s;
			foreach (e[i]) e[i] = (i < nb - 1) ? 2 : (i == nb - 1) ? 17 - 2 * (nb - 1) : 0;
			slow = s[0];
			run_frame("bar_count", 8'(s << 4) | 8'h03);
		end
		// Fixed mode with block 3: byte index modulo 3
		e = '{6, 6, 5, 0, 0, 0, 0, 0};
		run_frame("fixed_pattern", 8'h83);
		wr(8'h01, 8'h00);
		repeat (2) @(negedge clk_sys);
		check("busy_after_off", frame_busy, 1'b0);
		check("valid_after_off", byte_out.valid, 1'b0);
		c = cnt[0] + cnt[2] + cnt[3];
		repeat (500) @(negedge clk_sys);
		check("events_while_off", cnt[0] + cnt[2] + cnt[3], c);
		$display("test disable done");
		report_and_stop();
	end
endmodule : tpf_frame_timing_test
`default_nettype wire
